// [rtl/gsq_sequencer.sv]
// Controller-side bus sequencer that turns requests into bus messages
`timescale 1ns/1ps
// ==============================================================
module gsq_sequencer
   import gsq_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SYS_CTRL,
   input wire logic [4:0] MY_ADDR,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire gsq_req_t REQ,
   output gsq_rsp_t RSP,
   output logic ACTIVE_CTRL,
   output logic BUS_ATN,
   output logic BUS_IFC,
   output logic BUS_REN,
   output logic BUS_EOI,
   output logic [7:0] BYTE_DATA,
   output logic BYTE_VALID,
   input wire logic BYTE_DONE,
   output logic READ_REQ,
   input wire logic READ_VALID,
   input wire logic [7:0] READ_DATA
);

   // ===========================================================
   // State
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_STEP = 4'b0010,
      S_WAIT = 4'b0100,
      S_DONE = 4'b1000
   } gsq_state_t;

   gsq_state_t state, next_state;
   gsq_step_t seq [SEQ_LEN];
   gsq_step_t next_seq [SEQ_LEN];
   gsq_req_t req_q, next_req_q;
   logic [IDX_W-1:0] idx, next_idx;
   logic atn, next_atn;
   logic atn_saved, next_atn_saved;
   logic ifc, next_ifc;
   logic ren, next_ren;
   logic eoi, next_eoi;
   logic active, next_active;
   logic [7:0] obyte, next_obyte;
   logic ovalid, next_ovalid;
   logic rreq, next_rreq;
   gsq_rsp_t rsp, next_rsp;
   logic tmr_load;
   logic [TIMER_W-1:0] tmr_count;
   logic tmr_expired;
   logic legal;
   gsq_step_t cur;

   gsq_timer u_timer (
      .clk(SYS_CLK),
      .rst(RST),
      .ce(CE),
      .load(tmr_load),
      .count(tmr_count),
      .expired(tmr_expired)
   );

   function automatic gsq_step_t mk(gsq_kind_t k, logic [3:0] s, logic [7:0] c);
      gsq_step_t r;
      r.kind = k;
      r.sel = s;
      r.code = c;
      return r;
   endfunction

   // ===========================================================
   // Sequence builder: legality and ordered step list
   always_comb begin
      gsq_step_t b [SEQ_LEN];
      int n;
      for (int i = 0; i < SEQ_LEN; i++) begin
         b[i] = mk(ST_END, B_FIXED, 8'h00);
      end
      n = 0;
      legal = 1'b0;
      unique case (REQ.op)
         GSQ_ABORT: begin
            legal = 1'b1;
            if (SYS_CTRL) begin
               b[0] = mk(ST_IFC, B_FIXED, 8'h00);
               b[1] = mk(ST_REN, B_FIXED, 8'h00);
               b[2] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            end else if (active) begin
               b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
               b[1] = mk(ST_BYTE, B_MTA, 8'h00);
               b[2] = mk(ST_BYTE, B_FIXED, MSG_UNL);
               b[3] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            end
         end
         GSQ_CLEAR: begin
            legal = active;
            b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            if (!REQ.addressed) begin
               b[1] = mk(ST_BYTE, B_FIXED, MSG_DCL);
            end else begin
               b[1] = mk(ST_BYTE, B_MTA, 8'h00);
               b[2] = mk(ST_BYTE, B_FIXED, MSG_UNL);
               b[3] = mk(ST_BYTE, B_LAD, 8'h00);
               b[4] = mk(ST_BYTE, B_FIXED, MSG_SDC);
            end
         end
         GSQ_LOCKOUT: begin
            legal = active && !REQ.addressed;
            b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            b[1] = mk(ST_BYTE, B_FIXED, MSG_LLO);
         end
         GSQ_PASS: begin
            legal = active && REQ.addressed;
            b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            b[1] = mk(ST_BYTE, B_FIXED, MSG_UNL);
            b[2] = mk(ST_BYTE, B_TAD, 8'h00);
            b[3] = mk(ST_BYTE, B_FIXED, MSG_TCT);
            b[4] = mk(ST_ATN_OFF, B_MTA, 8'h01);
         end
         GSQ_PAR_POLL: begin
            legal = active && !REQ.addressed;
            b[0] = mk(ST_PAR_POLL, B_FIXED, 8'h00);
         end
         GSQ_PP_CFG: begin
            legal = active && REQ.addressed;
            b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            b[1] = mk(ST_BYTE, B_MTA, 8'h00);
            b[2] = mk(ST_BYTE, B_FIXED, MSG_UNL);
            b[3] = mk(ST_BYTE, B_LAD, 8'h00);
            b[4] = mk(ST_BYTE, B_FIXED, MSG_PPC);
            b[5] = mk(ST_BYTE, B_FIXED, MSG_PPE | {4'h0, REQ.ppe_code[3:0]});
         end
         GSQ_PP_UNCFG: begin
            legal = active;
            b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            if (!REQ.addressed) begin
               b[1] = mk(ST_BYTE, B_FIXED, MSG_PPU);
            end else begin
               b[1] = mk(ST_BYTE, B_MTA, 8'h00);
               b[2] = mk(ST_BYTE, B_FIXED, MSG_UNL);
               b[3] = mk(ST_BYTE, B_LAD, 8'h00);
               b[4] = mk(ST_BYTE, B_FIXED, MSG_PPC);
               b[5] = mk(ST_BYTE, B_FIXED, MSG_PPD);
            end
         end
         GSQ_REMOTE: begin
            legal = SYS_CTRL && (active || !REQ.addressed);
            b[0] = mk(ST_REN, B_FIXED, 8'h00);
            if (active) begin
               b[1] = mk(ST_ATN_ON, B_FIXED, 8'h00);
               if (REQ.addressed) begin
                  b[2] = mk(ST_BYTE, B_MTA, 8'h00);
                  b[3] = mk(ST_BYTE, B_FIXED, MSG_UNL);
                  b[4] = mk(ST_BYTE, B_LAD, 8'h00);
               end
            end
         end
         GSQ_SPOLL: begin
            legal = active && REQ.addressed;
            b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            b[1] = mk(ST_BYTE, B_FIXED, MSG_UNL);
            b[2] = mk(ST_BYTE, B_MLA, 8'h00);
            b[3] = mk(ST_BYTE, B_TAD, 8'h00);
            n = 4;
            if (REQ.has_secondary) begin
               b[4] = mk(ST_BYTE, B_SAD, 8'h00);
               n = 5;
            end
            b[n] = mk(ST_BYTE, B_FIXED, MSG_SPE);
            b[n + 1] = mk(ST_ATN_OFF, B_FIXED, 8'h00);
            b[n + 2] = mk(ST_READ, B_FIXED, 8'h00);
            b[n + 3] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            b[n + 4] = mk(ST_BYTE, B_FIXED, MSG_SPD);
            b[n + 5] = mk(ST_BYTE, B_FIXED, MSG_UNT);
         end
         GSQ_TRIGGER: begin
            legal = active;
            b[0] = mk(ST_ATN_ON, B_FIXED, 8'h00);
            if (!REQ.addressed) begin
               b[1] = mk(ST_BYTE, B_FIXED, MSG_GET);
            end else begin
               n = 1;
               if (!SYS_CTRL) begin
                  b[1] = mk(ST_BYTE, B_MTA, 8'h00);
                  n = 2;
               end
               b[n] = mk(ST_BYTE, B_FIXED, MSG_UNL);
               b[n + 1] = mk(ST_BYTE, B_LAD, 8'h00);
               b[n + 2] = mk(ST_BYTE, B_FIXED, MSG_GET);
            end
         end
         default: begin
            legal = 1'b0;
         end
      endcase
      next_seq = b;
   end

   // ===========================================================
   // Step executor
   assign cur = seq[idx];

   function automatic logic [7:0] pick(gsq_step_t s, gsq_req_t r, logic [4:0] me);
      logic [7:0] v;
      v = s.code;
      unique case (s.sel)
         B_MTA: v = TALK_BASE | {3'h0, me};
         B_MLA: v = LISTEN_BASE | {3'h0, me};
         B_LAD: v = LISTEN_BASE | {3'h0, r.primary};
         B_TAD: v = TALK_BASE | {3'h0, r.primary};
         B_SAD: v = SECOND_BASE | {3'h0, r.secondary};
         default: v = s.code;
      endcase
      return v;
   endfunction

   always_comb begin
      next_state = state;
      next_req_q = req_q;
      next_idx = idx;
      next_atn = atn;
      next_atn_saved = atn_saved;
      next_ifc = ifc;
      next_ren = ren;
      next_eoi = eoi;
      next_active = active;
      next_obyte = obyte;
      next_ovalid = ovalid;
      next_rreq = rreq;
      next_rsp = rsp;
      next_rsp.done = 1'b0;
      tmr_load = 1'b0;
      tmr_count = '0;
      unique case (state)
         S_IDLE: begin
            if (REQ_VALID) begin
               next_req_q = REQ;
               next_idx = '0;
               if (legal) begin
                  next_state = S_STEP;
               end else begin
                  // Nothing on the bus, attention untouched
                  next_rsp.error = 1'b1;
                  next_rsp.done = 1'b1;
               end
            end
         end
         S_STEP: begin
            unique case (cur.kind)
               ST_END: begin
                  next_rsp.error = 1'b0;
                  next_rsp.done = 1'b1;
                  next_state = S_IDLE;
               end
               ST_BYTE: begin
                  next_obyte = pick(cur, req_q, MY_ADDR);
                  next_ovalid = 1'b1;
                  next_state = S_WAIT;
               end
               ST_ATN_ON: begin
                  next_atn = 1'b1;
                  next_idx = idx + 4'h1;
               end
               ST_ATN_OFF: begin
                  next_atn = 1'b0;
                  if (cur.code[0]) begin
                     next_active = 1'b0;
                  end
                  next_idx = idx + 4'h1;
               end
               ST_IFC: begin
                  next_ifc = 1'b1;
                  tmr_load = 1'b1;
                  tmr_count = TIMER_W'(IFC_CYCLES);
                  next_state = S_WAIT;
               end
               ST_REN: begin
                  next_ren = 1'b1;
                  next_idx = idx + 4'h1;
               end
               ST_PAR_POLL: begin
                  next_atn_saved = atn;
                  next_atn = 1'b1;
                  next_eoi = 1'b1;
                  tmr_load = 1'b1;
                  tmr_count = TIMER_W'(PAR_POLL_CYCLES);
                  next_state = S_WAIT;
               end
               ST_READ: begin
                  next_rreq = 1'b1;
                  next_state = S_WAIT;
               end
               default: begin
                  next_state = S_IDLE;
               end
            endcase
         end
         S_WAIT: begin
            if (ovalid) begin
               if (BYTE_DONE) begin
                  next_ovalid = 1'b0;
                  next_idx = idx + 4'h1;
                  next_state = S_STEP;
               end
            end else if (ifc) begin
               if (tmr_expired) begin
                  next_ifc = 1'b0;
                  next_active = 1'b1;
                  next_idx = idx + 4'h1;
                  next_state = S_STEP;
               end
            end else if (eoi && !rreq) begin
               // Read only after the full poll hold time
               if (tmr_expired) begin
                  next_rreq = 1'b1;
               end
            end else if (rreq && READ_VALID) begin
               next_rreq = 1'b0;
               next_rsp.data = READ_DATA;
               if (eoi) begin
                  next_eoi = 1'b0;
                  next_atn = atn_saved;
               end
               next_idx = idx + 4'h1;
               next_state = S_STEP;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state <= S_IDLE;
         for (int i = 0; i < SEQ_LEN; i++) begin
            seq[i] <= '0;
         end
         req_q <= '0;
         idx <= '0;
         atn <= 1'b0;
         atn_saved <= 1'b0;
         ifc <= 1'b0;
         ren <= 1'b0;
         eoi <= 1'b0;
         active <= 1'b0;
         obyte <= 8'h00;
         ovalid <= 1'b0;
         rreq <= 1'b0;
         rsp <= '0;
      end else if (CE) begin
         state <= next_state;
         if (state == S_IDLE) begin
            seq <= next_seq;
         end
         req_q <= next_req_q;
         idx <= next_idx;
         atn <= next_atn;
         atn_saved <= next_atn_saved;
         ifc <= next_ifc;
         ren <= next_ren;
         eoi <= next_eoi;
         active <= next_active;
         obyte <= next_obyte;
         ovalid <= next_ovalid;
         rreq <= next_rreq;
         rsp <= next_rsp;
      end
   end

   // ===========================================================
   // Outputs
   assign REQ_READY = (state == S_IDLE) && CE;
   assign RSP = rsp;
   assign ACTIVE_CTRL = active;
   assign BUS_ATN = atn;
   assign BUS_IFC = ifc;
   assign BUS_REN = ren;
   assign BUS_EOI = eoi;
   assign BYTE_DATA = obyte;
   assign BYTE_VALID = ovalid;
   assign READ_REQ = rreq;

endmodule

// [rtl/gsq_pkg.sv]
// Package for the bus controller sequencer: opcodes, messages, timing
package gsq_pkg;

   // ===========================================================
   // Clock and timing
   localparam int CLK_MHZ = 200;
   localparam int IFC_MIN_US = 100;
   localparam int PAR_POLL_MIN_US = 25;
   localparam int IFC_CYCLES = IFC_MIN_US * CLK_MHZ;
   localparam int PAR_POLL_CYCLES = PAR_POLL_MIN_US * CLK_MHZ;
   localparam int TIMER_W = 16;

   // ===========================================================
   // Request opcodes
   typedef enum logic [3:0] {
      GSQ_ABORT = 4'h0,
      GSQ_CLEAR = 4'h1,
      GSQ_LOCKOUT = 4'h2,
      GSQ_PASS = 4'h3,
      GSQ_PAR_POLL = 4'h4,
      GSQ_PP_CFG = 4'h5,
      GSQ_PP_UNCFG = 4'h6,
      GSQ_REMOTE = 4'h7,
      GSQ_SPOLL = 4'h8,
      GSQ_TRIGGER = 4'h9
   } gsq_op_t;

   // ===========================================================
   // Step kinds of a sequence
   typedef enum logic [2:0] {
      ST_END = 3'h0,
      ST_BYTE = 3'h1,
      ST_ATN_ON = 3'h2,
      ST_ATN_OFF = 3'h3,
      ST_IFC = 3'h4,
      ST_REN = 3'h5,
      ST_PAR_POLL = 3'h6,
      ST_READ = 3'h7
   } gsq_kind_t;

   // Byte selectors for ST_BYTE steps
   localparam logic [3:0] B_FIXED = 4'h0;
   localparam logic [3:0] B_MTA = 4'h1;
   localparam logic [3:0] B_MLA = 4'h2;
   localparam logic [3:0] B_LAD = 4'h3;
   localparam logic [3:0] B_TAD = 4'h4;
   localparam logic [3:0] B_SAD = 4'h5;

   typedef struct packed {
      gsq_kind_t kind;
      logic [3:0] sel;
      logic [7:0] code;
   } gsq_step_t;

   // ===========================================================
   // Multiline message codes
   localparam logic [7:0] MSG_DCL = 8'h14;
   localparam logic [7:0] MSG_SDC = 8'h04;
   localparam logic [7:0] MSG_LLO = 8'h11;
   localparam logic [7:0] MSG_TCT = 8'h09;
   localparam logic [7:0] MSG_PPC = 8'h05;
   localparam logic [7:0] MSG_PPU = 8'h15;
   localparam logic [7:0] MSG_PPE = 8'h60;
   localparam logic [7:0] MSG_PPD = 8'h70;
   localparam logic [7:0] MSG_SPE = 8'h18;
   localparam logic [7:0] MSG_SPD = 8'h19;
   localparam logic [7:0] MSG_GET = 8'h08;
   localparam logic [7:0] MSG_UNL = 8'h3F;
   localparam logic [7:0] MSG_UNT = 8'h5F;
   localparam logic [7:0] LISTEN_BASE = 8'h20;
   localparam logic [7:0] TALK_BASE = 8'h40;
   localparam logic [7:0] SECOND_BASE = 8'h60;

   localparam int SEQ_LEN = 12;
   localparam int IDX_W = 4;

   // ===========================================================
   // Request and answer carriers
   typedef struct packed {
      gsq_op_t op;
      logic addressed;
      logic [4:0] primary;
      logic has_secondary;
      logic [4:0] secondary;
      logic [7:0] ppe_code;
   } gsq_req_t;

   typedef struct packed {
      logic done;
      logic error;
      logic [7:0] data;
   } gsq_rsp_t;

endpackage

// [rtl/gsq_timer.sv]
// Minimum-duration countdown timer for held bus lines
`timescale 1ns/1ps
module gsq_timer
   import gsq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic load,
   input wire logic [TIMER_W-1:0] count,
   output logic expired
);

   logic [TIMER_W-1:0] remain;
   logic [TIMER_W-1:0] next_remain;

   always_comb begin
      next_remain = remain;
      if (load) begin
         next_remain = count;
      end else if (remain != '0) begin
         next_remain = remain - 16'h0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remain <= '0;
      end else if (ce) begin
         remain <= next_remain;
      end
   end

   // Expired one cycle after the count reaches one, so hold is never short
   assign expired = (remain == '0) && !load;

endmodule

// [test/gsq_sequencer_assertions.sv]
// Assertion checker for the bus controller sequencer
`timescale 1ns/1ps
module gsq_sequencer_assertions
   import gsq_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic SYS_CTRL,
   input wire logic REQ_VALID,
   input wire logic REQ_READY,
   input wire gsq_req_t REQ,
   input wire gsq_rsp_t RSP,
   input wire logic ACTIVE_CTRL,
   input wire logic BUS_ATN,
   input wire logic BUS_IFC,
   input wire logic BUS_REN,
   input wire logic BUS_EOI,
   input wire logic [7:0] BYTE_DATA,
   input wire logic BYTE_VALID,
   input wire logic BYTE_DONE,
   input wire logic READ_REQ,
   input wire logic READ_VALID
);
   // ======================================
   // Helper logic
   logic take, refused;
   logic [31:0] ifc_len, eoi_len, next_ifc_len, next_eoi_len;
   assign take = REQ_VALID && REQ_READY && CE;
   always_comb begin
      case (REQ.op)
         GSQ_ABORT: refused = 1'b0;
         GSQ_LOCKOUT, GSQ_PAR_POLL: refused = !ACTIVE_CTRL || REQ.addressed;
         GSQ_PASS, GSQ_PP_CFG, GSQ_SPOLL: refused = !ACTIVE_CTRL || !REQ.addressed;
         GSQ_REMOTE: refused = !SYS_CTRL || (!ACTIVE_CTRL && REQ.addressed);
         default: refused = !ACTIVE_CTRL;
      endcase
   end
   // Counters also grow while frozen, so minimum widths stay safe
   always_comb begin
      next_ifc_len = BUS_IFC ? ifc_len + 32'h1 : 32'h0;
      next_eoi_len = BUS_EOI ? eoi_len + 32'h1 : 32'h0;
   end
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ifc_len <= 32'h0;
         eoi_len <= 32'h0;
      end else begin
         ifc_len <= next_ifc_len;
         eoi_len <= next_eoi_len;
      end
   end
   sequence byte_taken(logic [7:0] code);
      BYTE_VALID && BYTE_DONE && BYTE_DATA == code;
   endsequence
   // ======================================
   // Properties
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   refused_error_a:
      assert property (take && refused ##1 CE |-> RSP.done && RSP.error)
      else $error("refusal without error answer");
   refused_quiet_a:
      assert property (take && refused |=> $stable({BUS_ATN, BUS_IFC, BUS_REN, BUS_EOI})
         && !BYTE_VALID && !READ_REQ) else $error("refusal touched the bus");
   ifc_width_a:
      assert property ($fell(BUS_IFC) |-> ifc_len >= IFC_CYCLES) else $error("clear too short");
   abort_role_a:
      assert property ($fell(BUS_IFC) |-> ##[0:4] (ACTIVE_CTRL && BUS_REN && BUS_ATN))
      else $error("abort did not take role");
   eoi_width_a:
      assert property ($fell(BUS_EOI) |-> eoi_len >= PAR_POLL_CYCLES) else $error("poll too short");
   eoi_drop_a:
      assert property (READ_VALID && READ_REQ && BUS_EOI |-> BUS_ATN ##[1:3] !BUS_EOI)
      else $error("end line not dropped");
   handover_a:
      assert property (byte_taken(MSG_TCT) |-> ##[1:4] (!BUS_ATN && !ACTIVE_CTRL))
      else $error("role not released");
   spoll_release_a:
      assert property (byte_taken(MSG_SPE) |-> ##[1:3] !BUS_ATN ##[0:6] (READ_REQ && !BUS_ATN))
      else $error("poll read not under released attention");
   atn_idle_a:
      assert property (REQ_READY && !REQ_VALID |=> $stable(BUS_ATN))
      else $error("attention moved while idle");
endmodule

// [test/gsq_bus_model.sv]
// Behavioural model of the instruments on the far side of the bus
`timescale 1ns/1ps
module gsq_bus_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [7:0] rd_value,
   input wire logic atn,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_done,
   input wire logic read_req,
   output logic read_valid,
   output logic [7:0] read_data
);
   logic [7:0] sent[$];
   int atn_low = 0;
   int seed = 5;
   initial begin
      byte_done = 1'b0;
      read_valid = 1'b0;
      read_data = 8'h5A;
   end
   // Slow answers catch a sequencer that lets go too early
   function automatic int lag();
      return slow ? ($unsigned($random(seed)) % 4) + 1 : 0;
   endfunction
   always begin
      @(posedge clk);
      if (!rst && byte_valid && !byte_done) begin
         repeat (lag()) @(posedge clk);
         if (!atn) atn_low++;
         sent.push_back(byte_data);
         byte_done <= 1'b1;
         @(posedge clk);
         byte_done <= 1'b0;
      end
   end
   always begin
      @(posedge clk);
      if (!rst && read_req && !read_valid) begin
         repeat (lag()) @(posedge clk);
         read_data <= rd_value;
         read_valid <= 1'b1;
         @(posedge clk);
         read_valid <= 1'b0;
         read_data <= ~rd_value;
      end
   end
endmodule

// [test/gsq_sequencer_test.sv]
// Self-checking bench for the bus controller sequencer
`timescale 1ns/1ps
module gsq_sequencer_test
   import gsq_pkg::*;
;
   // ======================================
   // Signals and bench state
   logic SYS_CLK, RST, CE, SYS_CTRL, REQ_VALID, REQ_READY, ACTIVE_CTRL, slow;
   logic BUS_ATN, BUS_IFC, BUS_REN, BUS_EOI, BYTE_VALID, BYTE_DONE, READ_REQ, READ_VALID;
   logic [4:0] MY_ADDR;
   logic [7:0] BYTE_DATA, READ_DATA, rd_value;
   gsq_req_t REQ;
   gsq_rsp_t RSP;
   logic [7:0] exp_q[$];
   logic act = 1'b0, atn = 1'b0, ren = 1'b0;
   int failures = 0, comparisons = 0, cycles = 0, seed = 47;
   gsq_sequencer u_dut (
      .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .SYS_CTRL(SYS_CTRL), .MY_ADDR(MY_ADDR),
      .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .RSP(RSP),
      .ACTIVE_CTRL(ACTIVE_CTRL), .BUS_ATN(BUS_ATN), .BUS_IFC(BUS_IFC), .BUS_REN(BUS_REN),
      .BUS_EOI(BUS_EOI), .BYTE_DATA(BYTE_DATA), .BYTE_VALID(BYTE_VALID),
      .BYTE_DONE(BYTE_DONE), .READ_REQ(READ_REQ), .READ_VALID(READ_VALID),
      .READ_DATA(READ_DATA)
   );
   gsq_bus_model u_bus (
      .clk(SYS_CLK), .rst(RST), .slow(slow), .rd_value(rd_value), .atn(BUS_ATN),
      .byte_valid(BYTE_VALID), .byte_data(BYTE_DATA), .byte_done(BYTE_DONE),
      .read_req(READ_REQ), .read_valid(READ_VALID), .read_data(READ_DATA)
   );
   initial begin
      SYS_CLK = 1'b0;
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // One long clear and a few polls fit well inside this
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 100000) begin
         failures++;
         give_verdict();
      end
   end
   // ======================================
   // One request, its expected bytes and end state
   task automatic run(input gsq_op_t op, input logic ad, input logic sys);
      gsq_req_t r;
      logic err;
      logic [4:0] me;
      logic [7:0] mta, lad, tad, rd;
      r = gsq_req_t'(24'($random(seed)));
      r.op = op;
      r.addressed = ad;
      me = 5'($random(seed));
      rd = 8'($random(seed));
      mta = TALK_BASE | {3'h0, me};
      lad = LISTEN_BASE | {3'h0, r.primary};
      tad = TALK_BASE | {3'h0, r.primary};
      case (op)
         GSQ_ABORT: err = 1'b0;
         GSQ_LOCKOUT, GSQ_PAR_POLL: err = !act || ad;
         GSQ_PASS, GSQ_PP_CFG, GSQ_SPOLL: err = !act || !ad;
         GSQ_REMOTE: err = !sys || (!act && ad);
         default: err = !act;
      endcase
      exp_q.delete();
      if (!err && ad && op inside {GSQ_CLEAR, GSQ_PP_CFG, GSQ_PP_UNCFG, GSQ_REMOTE, GSQ_TRIGGER})
      begin
         if (op != GSQ_TRIGGER || !sys) exp_q.push_back(mta);
         exp_q.push_back(MSG_UNL);
         exp_q.push_back(lad);
      end
      if (!err) begin
         case (op)
            GSQ_ABORT: if (!sys && act) exp_q = '{mta, MSG_UNL};
            GSQ_CLEAR: exp_q.push_back(ad ? MSG_SDC : MSG_DCL);
            GSQ_LOCKOUT: exp_q.push_back(MSG_LLO);
            GSQ_PASS: exp_q = '{MSG_UNL, tad, MSG_TCT};
            GSQ_PP_CFG: exp_q = {exp_q, MSG_PPC, MSG_PPE | {4'h0, r.ppe_code[3:0]}};
            GSQ_PP_UNCFG: exp_q = {exp_q, ad ? MSG_PPC : MSG_PPU};
            GSQ_SPOLL: begin
               exp_q = '{MSG_UNL, LISTEN_BASE | {3'h0, me}, tad};
               if (r.has_secondary) exp_q.push_back(SECOND_BASE | {3'h0, r.secondary});
               exp_q = {exp_q, MSG_SPE, MSG_SPD, MSG_UNT};
            end
            GSQ_TRIGGER: exp_q.push_back(MSG_GET);
            default: ;
         endcase
         if (op == GSQ_PP_UNCFG && ad) exp_q.push_back(MSG_PPD);
      end
      u_bus.sent.delete();
      u_bus.atn_low = 0;
      @(posedge SYS_CLK);
      slow <= 1'($random(seed));
      rd_value <= rd;
      SYS_CTRL <= sys;
      MY_ADDR <= me;
      REQ <= r;
      REQ_VALID <= 1'b1;
      do @(posedge SYS_CLK); while (REQ_READY !== 1'b1);
      REQ_VALID <= 1'b0;
      do @(posedge SYS_CLK); while (RSP.done !== 1'b1);
      check(16'(RSP.error), 16'(err));
      check(16'(u_bus.sent.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) check({8'h0, u_bus.sent[i]}, {8'h0, exp_q[i]});
      check(16'(u_bus.atn_low), 16'h0);
      if (!err) begin
         case (op)
            GSQ_ABORT: atn = act | sys;
            GSQ_PASS: atn = 1'b0;
            GSQ_PAR_POLL: ;
            GSQ_REMOTE: atn = atn | act;
            default: atn = 1'b1;
         endcase
         ren = ren | (sys && op inside {GSQ_ABORT, GSQ_REMOTE});
         act = (op == GSQ_PASS) ? 1'b0 : act | (sys && op == GSQ_ABORT);
      end
      check({ACTIVE_CTRL, BUS_ATN, BUS_REN, BUS_IFC, BUS_EOI}, {act, atn, ren, 2'b00});
      if (!err && op inside {GSQ_PAR_POLL, GSQ_SPOLL}) check({8'h0, RSP.data}, {8'h0, rd});
      $display("request %0d addressed %0d finished", op, ad);
   endtask
   // ======================================
   // Main sequence
   initial begin
      gsq_op_t op;
      RST = 1'b1;
      CE = 1'b1;
      SYS_CTRL = 1'b0;
      MY_ADDR = 5'h00;
      REQ_VALID = 1'b0;
      REQ = '0;
      slow = 1'b0;
      rd_value = 8'h00;
      repeat (20) @(posedge SYS_CLK);
      RST <= 1'b0;
      for (int i = 0; i < 12; i++)
         run(gsq_op_t'(4'h1 + 4'(i % 9)), 1'($random(seed)), 1'($random(seed)));
      run(GSQ_ABORT, 1'b0, 1'b0);
      run(GSQ_ABORT, 1'b0, 1'b1);
      // Every code but abort and pass in both forms first; long polls kept out of random traffic
      for (int i = 0; i < 48; i++) begin
         op = gsq_op_t'(4'h1 + 4'((i < 18) ? i % 9 : $unsigned($random(seed)) % 9));
         if (op == GSQ_PASS || (i >= 18 && op == GSQ_PAR_POLL)) op = GSQ_PP_UNCFG;
         run(op, (i < 18) ? 1'(i / 9) : 1'($random(seed)), 1'($random(seed)));
      end
      CE <= 1'b0;
      @(posedge SYS_CLK);
      @(posedge SYS_CLK);
      check(16'(REQ_READY), 16'h0);
      CE <= 1'b1;
      run(GSQ_ABORT, 1'b0, 1'b0);
      run(GSQ_PASS, 1'b0, 1'b1);
      run(GSQ_PASS, 1'b1, 1'b0);
      run(GSQ_TRIGGER, 1'b1, 1'b1);
      give_verdict();
   end
endmodule
bind gsq_sequencer gsq_sequencer_assertions u_chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .SYS_CTRL(SYS_CTRL), .REQ_VALID(REQ_VALID),
   .REQ_READY(REQ_READY), .REQ(REQ), .RSP(RSP), .ACTIVE_CTRL(ACTIVE_CTRL), .BUS_ATN(BUS_ATN),
   .BUS_IFC(BUS_IFC), .BUS_REN(BUS_REN), .BUS_EOI(BUS_EOI), .BYTE_DATA(BYTE_DATA),
   .BYTE_VALID(BYTE_VALID), .BYTE_DONE(BYTE_DONE), .READ_REQ(READ_REQ), .READ_VALID(READ_VALID)
);
